// File: gcp_defines.vh
// Constants shared by the common command parser and its state memory
`ifndef GCP_DEFINES_VH
`define GCP_DEFINES_VH
// Widths
`define GCP_STATE_W 32
`define GCP_SLOTS 10
`define GCP_MAX_SLOT 32'h00000009
`define GCP_MAX_BYTE 32'h000000FF
`define GCP_HDR_MAX 3'h6
`define GCP_SFX_MAX 2'h3
// Characters
`define GCP_CH_LF 8'h0A
`define GCP_CH_SEMI 8'h3B
`define GCP_CH_SP 8'h20
`define GCP_CH_COMMA 8'h2C
`define GCP_CH_DOT 8'h2E
`define GCP_CH_STAR 8'h2A
`define GCP_CH_QM 8'h3F
`define GCP_CH_0 8'h30
`define GCP_CH_9 8'h39
`define GCP_CH_A 8'h41
`define GCP_CH_Z 8'h5A
`define GCP_CH_LA 8'h61
`define GCP_CH_LZ 8'h7A
`define GCP_CASE_BIT 5
// Common command headers, right aligned
`define GCP_H_IDNQ 48'h002A49444E3F
`define GCP_H_RST 48'h00002A525354
`define GCP_H_TSTQ 48'h002A5453543F
`define GCP_H_OPC 48'h00002A4F5043
`define GCP_H_OPCQ 48'h002A4F50433F
`define GCP_H_WAI 48'h00002A574149
`define GCP_H_CLS 48'h00002A434C53
`define GCP_H_ESE 48'h00002A455345
`define GCP_H_ESEQ 48'h002A4553453F
`define GCP_H_ESRQ 48'h002A4553523F
`define GCP_H_SRE 48'h00002A535245
`define GCP_H_SREQ 48'h002A5352453F
`define GCP_H_STBQ 48'h002A5354423F
`define GCP_H_TRG 48'h00002A545247
`define GCP_H_RCL 48'h00002A52434C
`define GCP_H_SAV 48'h00002A534156
// Suffix codes, right aligned, upper case
`define GCP_S_GHZ 24'h47485A
`define GCP_S_G 24'h000047
`define GCP_S_MHZ 24'h4D485A
`define GCP_S_MA 24'h004D41
`define GCP_S_KHZ 24'h4B485A
`define GCP_S_K 24'h00004B
`define GCP_S_HZ 24'h00485A
`define GCP_S_NONE 24'h000000
`define GCP_S_S 24'h000053
`define GCP_S_MS 24'h004D53
`define GCP_S_M 24'h00004D
`define GCP_S_US 24'h005553
`define GCP_S_U 24'h000055
`define GCP_S_NS 24'h004E53
`define GCP_S_N 24'h00004E
// Decimal exponents of the suffixes
`define GCP_EXP_9 6'h09
`define GCP_EXP_6 6'h06
`define GCP_EXP_3 6'h03
`define GCP_EXP_0 6'h00
// Unit kinds
`define GCP_U_NONE 2'h0
`define GCP_U_HZ 2'h1
`define GCP_U_NS 2'h2
// Event status bits
`define GCP_ESR_OPC 0
`define GCP_ESR_EXE 4
`define GCP_ESR_CME 5
`define GCP_ESR_RESET 8'h80
// Status byte bits
`define GCP_STB_END 0
`define GCP_STB_ERR 1
`define GCP_STB_MAV 4
`define GCP_STB_ESB 5
`define GCP_STB_MSS 6
`define GCP_SRE_MASK 8'hBF
// Identify response prefix, arbitrary model and maker text "FC01,GEN0,0,"
`define GCP_IDN_PFX 96'h464330312C47454E302C302C
`define GCP_IDN_LEN 5'h0C
`endif

// File: gcp_host_model.sv
// Bus controller model: sends program messages, collects responses
`timescale 1ns/10ps
module gcp_host_model (
   input wire clock,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire rx_ready,
   input wire [7:0] tx_data,
   input wire tx_valid,
   output logic tx_ready
);
   bit slow = 1'b0;
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end
   // One ASCII message, a byte per accepting edge
   task automatic send(input string s);
      foreach (s[i]) begin
         rx_data <= s[i];
         rx_valid <= 1'b1;
         do @(negedge clock); while (!rx_ready);
         @(posedge clock);
      end
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
   endtask
   // Packs response bytes up to the closing line feed; slow stalls
   task automatic recv(output logic [127:0] v);
      logic got;
      logic [7:0] c;
      v = 128'h0;
      tx_ready <= 1'b1;
      repeat (600) begin
         @(negedge clock);
         got = tx_valid && tx_ready;
         c = tx_data;
         @(posedge clock);
         if (got && c == 8'h0A) break;
         if (got) v = {v[119:0], c};
         tx_ready <= !slow || !tx_ready;
      end
      tx_ready <= 1'b0;
   endtask
endmodule // gcp_host_model

// File: gcp_parser.v
// Common command parser: messages in, responses out, status registers
`timescale 1ns/10ps
`include "gcp_defines.vh"
module gcp_parser #(
   parameter [15:0] FW_VERSION = 16'h0001
) (
   input wire clock,
   input wire resetn,
   input wire [7:0] rx_data,
   input wire rx_valid,
   output wire rx_ready,
   output reg [7:0] tx_data,
   output wire tx_valid,
   input wire tx_ready,
   input wire get_in,
   input wire ops_busy,
   input wire [14:0] tst_fail,
   input wire end_summary,
   input wire err_summary,
   input wire [`GCP_STATE_W-1:0] state_snapshot,
   output reg preset,
   output reg trigger,
   output reg clear_status,
   output reg state_load,
   output wire [`GCP_STATE_W-1:0] state_data,
   output reg dev_msg,
   output reg [47:0] dev_header,
   output reg [31:0] dev_value,
   output reg [1:0] dev_unit,
   output reg [7:0] event_status_reg,
   output reg [7:0] event_enable_reg,
   output reg [7:0] service_enable_reg,
   output wire [7:0] status_byte,
   output wire srq
);
   localparam [2:0] ST_HDR = 3'h0;
   localparam [2:0] ST_ARG = 3'h1;
   localparam [2:0] ST_SCALE = 3'h2;
   localparam [2:0] ST_EXEC = 3'h3;
   localparam [2:0] ST_WAIT = 3'h4;
   localparam [2:0] ST_RESP = 3'h5;
   localparam [2:0] ST_RCL = 3'h6;
   // Identify prefix held as a constant so that it can be indexed
   localparam [95:0] IDN_PFX = `GCP_IDN_PFX;

   reg [2:0] state;
   reg [47:0] hdr;
   reg [2:0] hdr_len;
   reg [23:0] sfx;
   reg [1:0] sfx_len;
   reg [31:0] mant;
   reg [5:0] frac;
   reg seen_dot;
   reg has_num;
   reg bad;
   reg [5:0] exp_adj;
   reg [1:0] unit;
   reg wait_resp;
   reg opc_pend;
   reg cme_pulse;
   reg resp_idn;
   reg [15:0] resp_num;
   reg [4:0] resp_pos;
   reg tx_full;
   reg [7:0] ch;
   reg [5:0] sfx_exp;
   reg [1:0] sfx_unit;
   reg sfx_bad;
   reg [7:0] next_char;
   reg [2:0] nd;
   reg [4:0] pfx_len;
   reg [4:0] k;
   reg [2:0] di;
   wire [19:0] digv;
   wire take;
   wire is_dig;
   wire is_alpha;
   wire is_term;
   wire is_exec;
   wire esr_clr;
   wire exec_cme;
   wire exec_exe;
   wire opc_set;
   wire mav;
   wire event_summary_bit;
   wire [7:0] stb_low;

   assign rx_ready = (state == ST_HDR) || (state == ST_ARG);
   assign take = rx_valid && rx_ready;
   assign tx_valid = (state == ST_RESP) && tx_full;

   // Fold lower case onto upper case before any matching
   always @* begin
      ch = rx_data;
      if (rx_data >= `GCP_CH_LA && rx_data <= `GCP_CH_LZ) begin
         ch[`GCP_CASE_BIT] = 1'b0;
      end
   end

   assign is_dig = (ch >= `GCP_CH_0) && (ch <= `GCP_CH_9);
   assign is_alpha = (ch >= `GCP_CH_A) && (ch <= `GCP_CH_Z);
   assign is_term = (ch == `GCP_CH_LF) || (ch == `GCP_CH_SEMI);

   // Suffix decode: exponent to integer hertz or nanoseconds
   always @* begin
      sfx_bad = 1'b0;
      sfx_exp = `GCP_EXP_0;
      sfx_unit = `GCP_U_NONE;
      case (sfx)
         `GCP_S_GHZ, `GCP_S_G: begin
            sfx_exp = `GCP_EXP_9;
            sfx_unit = `GCP_U_HZ;
         end
         `GCP_S_MHZ, `GCP_S_MA: begin
            sfx_exp = `GCP_EXP_6;
            sfx_unit = `GCP_U_HZ;
         end
         `GCP_S_KHZ, `GCP_S_K: begin
            sfx_exp = `GCP_EXP_3;
            sfx_unit = `GCP_U_HZ;
         end
         `GCP_S_HZ: sfx_unit = `GCP_U_HZ;
         `GCP_S_NONE: sfx_unit = `GCP_U_NONE;
         `GCP_S_S: begin
            sfx_exp = `GCP_EXP_9;
            sfx_unit = `GCP_U_NS;
         end
         `GCP_S_MS, `GCP_S_M: begin
            sfx_exp = `GCP_EXP_6;
            sfx_unit = `GCP_U_NS;
         end
         `GCP_S_US, `GCP_S_U: begin
            sfx_exp = `GCP_EXP_3;
            sfx_unit = `GCP_U_NS;
         end
         `GCP_S_NS, `GCP_S_N: sfx_unit = `GCP_U_NS;
         default: sfx_bad = 1'b1;
      endcase
   end

   // Decimal digits of the response number
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_dig
         localparam [15:0] POW = 10 ** gi;
         wire [15:0] quo = resp_num / POW;
         wire [15:0] rem = quo % 16'h000A;
         assign digv[gi*4 +: 4] = rem[3:0];
      end
   endgenerate

   // Next response character: prefix, digits without leading zeros, LF
   always @* begin
      if (resp_num >= 16'h2710)
         nd = 3'h5;
      else if (resp_num >= 16'h03E8)
         nd = 3'h4;
      else if (resp_num >= 16'h0064)
         nd = 3'h3;
      else if (resp_num >= 16'h000A)
         nd = 3'h2;
      else
         nd = 3'h1;
      pfx_len = resp_idn ? `GCP_IDN_LEN : 5'h00;
      k = resp_pos - pfx_len;
      di = nd - 3'h1 - k[2:0];
      if (resp_pos < pfx_len) begin
         next_char = IDN_PFX[(`GCP_IDN_LEN - 5'h01 - resp_pos) * 8 +: 8];
      end else if (k < {2'h0, nd}) begin
         next_char = `GCP_CH_0 + {4'h0, digv[di*4 +: 4]};
      end else begin
         next_char = `GCP_CH_LF;
      end
   end

   // Command decode in the execute cycle
   assign is_exec = (state == ST_EXEC) && !bad;
   assign esr_clr = is_exec && (hdr == `GCP_H_CLS || hdr == `GCP_H_ESRQ);
   assign exec_cme = (state == ST_EXEC) && (bad ||
      (hdr_is_star(hdr) && !known(hdr)));
   assign exec_exe = is_exec && (((hdr == `GCP_H_ESE || hdr == `GCP_H_SRE)
      && (!has_num || mant > `GCP_MAX_BYTE)) ||
      ((hdr == `GCP_H_SAV || hdr == `GCP_H_RCL) &&
      (!has_num || mant > `GCP_MAX_SLOT)));
   assign opc_set = opc_pend && !ops_busy;

   // Star in the leading position of a right-aligned header of four to six characters
   function hdr_is_star;
      input [47:0] h;
      begin
         hdr_is_star = (h[47:40] == `GCP_CH_STAR) ||
            (h[39:32] == `GCP_CH_STAR && h[47:40] == 8'h00) ||
            (h[31:24] == `GCP_CH_STAR && h[47:32] == 16'h0000);
      end
   endfunction

   function known;
      input [47:0] h;
      begin
         case (h)
            `GCP_H_IDNQ, `GCP_H_RST, `GCP_H_TSTQ, `GCP_H_OPC, `GCP_H_OPCQ,
            `GCP_H_WAI, `GCP_H_CLS, `GCP_H_ESE, `GCP_H_ESEQ, `GCP_H_ESRQ,
            `GCP_H_SRE, `GCP_H_SREQ, `GCP_H_STBQ, `GCP_H_TRG, `GCP_H_RCL,
            `GCP_H_SAV: known = 1'b1;
            default: known = 1'b0;
         endcase
      end
   endfunction

   // Event status register; an event in the clearing cycle survives
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         event_status_reg <= `GCP_ESR_RESET;
      end else begin
         event_status_reg <= (esr_clr ? 8'h00 : event_status_reg) |
            ({7'h00, opc_set} << `GCP_ESR_OPC) |
            ({7'h00, exec_exe} << `GCP_ESR_EXE) |
            ({7'h00, exec_cme | cme_pulse} << `GCP_ESR_CME);
      end
   end

   // Status byte and service request
   assign mav = (state == ST_RESP);
   assign event_summary_bit = |(event_status_reg & event_enable_reg);
   assign stb_low = ({7'h00, end_summary} << `GCP_STB_END) |
      ({7'h00, err_summary} << `GCP_STB_ERR) |
      ({7'h00, mav} << `GCP_STB_MAV) | ({7'h00, event_summary_bit} << `GCP_STB_ESB);
   assign srq = |(stb_low & service_enable_reg & `GCP_SRE_MASK);
   assign status_byte = stb_low | ({7'h00, srq} << `GCP_STB_MSS);

   // Saved state memory
   gcp_state_mem gcp_state_mem_inst (
      .clock(clock),
      .wr_en(is_exec && !exec_exe && hdr == `GCP_H_SAV),
      .wr_addr(mant[3:0]),
      .wr_data(state_snapshot),
      .rd_en(is_exec && !exec_exe && hdr == `GCP_H_RCL),
      .rd_addr(mant[3:0]),
      .rd_data(state_data)
   );

   // Parser, scaler, executor and response sender
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= ST_HDR;
         hdr <= 48'h000000000000;
         hdr_len <= 3'h0;
         sfx <= 24'h000000;
         sfx_len <= 2'h0;
         mant <= 32'h00000000;
         frac <= 6'h00;
         seen_dot <= 1'b0;
         has_num <= 1'b0;
         bad <= 1'b0;
         exp_adj <= 6'h00;
         unit <= `GCP_U_NONE;
         wait_resp <= 1'b0;
         opc_pend <= 1'b0;
         cme_pulse <= 1'b0;
         resp_idn <= 1'b0;
         resp_num <= 16'h0000;
         resp_pos <= 5'h00;
         tx_full <= 1'b0;
         tx_data <= 8'h00;
         preset <= 1'b0;
         trigger <= 1'b0;
         clear_status <= 1'b0;
         state_load <= 1'b0;
         dev_msg <= 1'b0;
         dev_header <= 48'h000000000000;
         dev_value <= 32'h00000000;
         dev_unit <= `GCP_U_NONE;
         event_enable_reg <= 8'h00;
         service_enable_reg <= 8'h00;
      end else begin
         preset <= 1'b0;
         trigger <= 1'b0;
         clear_status <= 1'b0;
         state_load <= 1'b0;
         dev_msg <= 1'b0;
         cme_pulse <= 1'b0;
         if (opc_set) begin
            opc_pend <= 1'b0;
         end
         if (get_in) begin
            if (state == ST_HDR && hdr_len == 3'h0) begin
               trigger <= 1'b1;
            end else if (rx_ready) begin
               cme_pulse <= 1'b1;
               state <= ST_HDR;
               hdr <= 48'h000000000000;
               hdr_len <= 3'h0;
            end
         end else begin
            case (state)
               ST_HDR: if (take) begin
                  sfx <= 24'h000000;
                  sfx_len <= 2'h0;
                  mant <= 32'h00000000;
                  frac <= 6'h00;
                  seen_dot <= 1'b0;
                  has_num <= 1'b0;
                  if (is_term) begin
                     if (hdr_len != 3'h0) begin
                        exp_adj <= 6'h00;
                        unit <= `GCP_U_NONE;
                        state <= ST_EXEC;
                     end
                  end else if (ch == `GCP_CH_SP) begin
                     if (hdr_len != 3'h0) begin
                        state <= ST_ARG;
                     end
                  end else begin
                     if (hdr_len == 3'h0) begin
                        bad <= 1'b0;
                     end
                     if (hdr_len == `GCP_HDR_MAX || !(is_alpha ||
                        ch == `GCP_CH_STAR || ch == `GCP_CH_QM)) begin
                        bad <= 1'b1;
                     end else begin
                        hdr_len <= hdr_len + 3'h1;
                     end
                     hdr <= {hdr[39:0], ch};
                  end
               end
               ST_ARG: if (take) begin
                  if (is_term) begin
                     exp_adj <= sfx_exp - frac;
                     unit <= sfx_unit;
                     if (sfx_bad) begin
                        bad <= 1'b1;
                     end
                     state <= ST_SCALE;
                  end else if (is_dig && sfx_len == 2'h0) begin
                     mant <= mant * 32'h0000000A + {24'h000000, ch - `GCP_CH_0};
                     has_num <= 1'b1;
                     if (seen_dot) begin
                        frac <= frac + 6'h01;
                     end
                  end else if (ch == `GCP_CH_DOT && !seen_dot) begin
                     seen_dot <= 1'b1;
                  end else if (is_alpha && sfx_len != `GCP_SFX_MAX) begin
                     sfx <= {sfx[15:0], ch};
                     sfx_len <= sfx_len + 2'h1;
                  end else if (ch != `GCP_CH_SP && ch != `GCP_CH_COMMA) begin
                     bad <= 1'b1;
                  end
               end
               ST_SCALE: begin
                  if (exp_adj == 6'h00) begin
                     state <= ST_EXEC;
                  end else if (exp_adj[5]) begin
                     mant <= mant / 32'h0000000A;
                     exp_adj <= exp_adj + 6'h01;
                  end else begin
                     mant <= mant * 32'h0000000A;
                     exp_adj <= exp_adj - 6'h01;
                  end
               end
               ST_EXEC: begin
                  state <= ST_HDR;
                  hdr_len <= 3'h0;
                  hdr <= 48'h000000000000;
                  resp_idn <= 1'b0;
                  resp_pos <= 5'h00;
                  tx_full <= 1'b0;
                  if (!bad && !exec_exe) begin
                     case (hdr)
                        `GCP_H_IDNQ: begin
                           resp_idn <= 1'b1;
                           resp_num <= FW_VERSION;
                           state <= ST_RESP;
                        end
                        `GCP_H_RST: preset <= 1'b1;
                        `GCP_H_TSTQ: begin
                           resp_num <= {1'b0, tst_fail};
                           state <= ST_RESP;
                        end
                        `GCP_H_OPC: opc_pend <= 1'b1;
                        `GCP_H_OPCQ: begin
                           wait_resp <= 1'b1;
                           state <= ST_WAIT;
                        end
                        `GCP_H_WAI: begin
                           wait_resp <= 1'b0;
                           state <= ST_WAIT;
                        end
                        `GCP_H_CLS: begin
                           opc_pend <= 1'b0;
                           clear_status <= 1'b1;
                        end
                        `GCP_H_ESE: event_enable_reg <= mant[7:0];
                        `GCP_H_SRE: service_enable_reg <= mant[7:0];
                        `GCP_H_ESEQ, `GCP_H_ESRQ, `GCP_H_SREQ, `GCP_H_STBQ: begin
                           state <= ST_RESP;
                           if (hdr == `GCP_H_ESEQ)
                              resp_num <= {8'h00, event_enable_reg};
                           else if (hdr == `GCP_H_ESRQ)
                              resp_num <= {8'h00, event_status_reg};
                           else if (hdr == `GCP_H_SREQ)
                              resp_num <= {8'h00, service_enable_reg};
                           else
                              resp_num <= {8'h00, status_byte};
                        end
                        `GCP_H_TRG: trigger <= 1'b1;
                        `GCP_H_RCL: state <= ST_RCL;
                        `GCP_H_SAV: state <= ST_HDR;
                        default: if (!hdr_is_star(hdr)) begin
                           dev_msg <= 1'b1;
                           dev_header <= hdr;
                           dev_value <= mant;
                           dev_unit <= unit;
                        end
                     endcase
                  end
               end
               ST_WAIT: if (!ops_busy) begin
                  if (wait_resp) begin
                     resp_num <= 16'h0001;
                     state <= ST_RESP;
                  end else begin
                     state <= ST_HDR;
                  end
               end
               ST_RESP: begin
                  if (!tx_full) begin
                     tx_data <= next_char;
                     tx_full <= 1'b1;
                  end else if (tx_ready) begin
                     tx_full <= 1'b0;
                     resp_pos <= resp_pos + 5'h01;
                     if (tx_data == `GCP_CH_LF) begin
                        state <= ST_HDR;
                     end
                  end
               end
               ST_RCL: begin
                  state_load <= 1'b1;
                  state <= ST_HDR;
               end
               default: state <= ST_HDR;
            endcase
         end
      end
   end
endmodule // gcp_parser

// File: gcp_parser_properties.sv
// Port assertions for the common command parser
`timescale 1ns/10ps
module gcp_parser_properties (
   input wire clock,
   input wire resetn,
   input wire [7:0] tx_data,
   input wire tx_valid,
   input wire tx_ready,
   input wire ops_busy,
   input wire preset,
   input wire trigger,
   input wire [7:0] event_status_reg,
   input wire [7:0] event_enable_reg,
   input wire [7:0] service_enable_reg,
   input wire [7:0] status_byte,
   input wire srq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // Summary and request bits follow their enables
   property p_esb; status_byte[5] == |(event_status_reg & event_enable_reg);
   endproperty
   a_esb: assert property (p_esb) else $error("summary bit wrong");
   property p_srq; srq == |(status_byte & service_enable_reg & 8'hBF);
   endproperty
   a_srq: assert property (p_srq) else $error("request wrong");
   property p_mss; status_byte[6] == srq; endproperty
   a_mss: assert property (p_mss) else $error("master bit wrong");
   property p_rsv; status_byte[7] == 1'b0 && status_byte[3:2] == 2'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("unused bit set");
   // A stalled response byte stands
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_hold: assert property (p_hold) else $error("response moved");
   // Completion bit only once earlier work is over
   property p_opc; $rose(event_status_reg[0]) |-> !$past(ops_busy);
   endproperty
   a_opc: assert property (p_opc) else $error("early completion");
   property p_pre; preset |=> !preset; endproperty
   a_pre: assert property (p_pre) else $error("preset too long");
   property p_trg; trigger |=> !trigger; endproperty
   a_trg: assert property (p_trg) else $error("trigger too long");
endmodule // gcp_parser_properties
bind gcp_parser gcp_parser_properties gcp_parser_properties_inst (.clock,
   .resetn, .tx_data, .tx_valid, .tx_ready, .ops_busy, .preset, .trigger,
   .event_status_reg, .event_enable_reg, .service_enable_reg, .status_byte,
   .srq);

// File: gcp_parser_tb_top.sv
// Self-checking bench for the common command parser
`timescale 1ns/10ps
module gcp_parser_tb_top;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic get_in = 1'b0;
   logic ops_busy = 1'b0;
   logic end_summary = 1'b0;
   logic err_summary = 1'b0;
   logic [14:0] tst_fail = 15'h0;
   logic [31:0] state_snapshot = 32'h0;
   wire [7:0] rx_data, tx_data, event_status_reg, event_enable_reg;
   wire [7:0] service_enable_reg, status_byte;
   wire rx_valid, rx_ready, tx_valid, tx_ready, preset, trigger;
   wire state_load, srq, dev_msg, clear_status;
   wire [47:0] dev_header;
   wire [31:0] state_data, dev_value;
   wire [1:0] dev_unit;
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int trig_n = 0;
   int pre_n = 0;
   int cls_n = 0;
   logic [31:0] ld, val;
   logic [1:0] unit;
   logic [127:0] resp;
   string sm[15] = '{"F 2ghz", "F 3G", "F 4mhz", "F 5ma", "F 6KHZ",
      "F 1.5k", "F 8HZ", "F 9", "T 1S", "T 2ms", "T 3M", "T 4US", "T 5u",
      "T 6NS", "T 7n"};
   logic [31:0] sv[15] = '{32'h77359400, 32'hB2D05E00, 32'h3D0900,
      32'h4C4B40, 32'h1770, 32'h5DC, 32'h8, 32'h9, 32'h3B9ACA00, 32'h1E8480,
      32'h2DC6C0, 32'hFA0, 32'h1388, 32'h6, 32'h7};
   gcp_parser gcp_parser_inst (.clock, .resetn, .rx_data, .rx_valid,
      .rx_ready, .tx_data, .tx_valid, .tx_ready, .get_in, .ops_busy,
      .tst_fail, .end_summary, .err_summary, .state_snapshot, .preset,
      .trigger, .clear_status, .state_load, .state_data, .dev_msg,
      .dev_header, .dev_value, .dev_unit, .event_status_reg,
      .event_enable_reg, .service_enable_reg, .status_byte, .srq);
   gcp_host_model gcp_host_model_inst (.clock, .rx_data, .rx_valid,
      .rx_ready, .tx_data, .tx_valid, .tx_ready);
   initial forever #50 clock = ~clock;
   // Pulse counts, handed values and the hang limit
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (trigger) trig_n <= trig_n + 1;
      if (preset) pre_n <= pre_n + 1;
      if (clear_status) cls_n <= cls_n + 1;
      if (state_load) ld <= state_data;
      if (dev_msg) val <= dev_value;
      if (dev_msg) unit <= dev_unit;
      if (cyc == 6000) begin
         err_count = err_count + 1;
         end_sim();
      end
   end
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Command, then wait until input is accepted again
   task automatic cmd(input string s);
      gcp_host_model_inst.send({s, "\n"});
      repeat (200) begin
         @(negedge clock);
         if (rx_ready) break;
      end
      // Two more edges so pulse counters and captures have settled
      repeat (2) @(posedge clock);
   endtask
   task automatic q(input string s, input logic [127:0] exp);
      gcp_host_model_inst.send({s, "\n"});
      gcp_host_model_inst.recv(resp);
      chk(resp, exp);
   endtask
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      chk(event_status_reg, 8'h80);
      q("*ESR?", "128");
      chk(event_status_reg, 8'h00);
      cmd("*ESE 256");
      chk(event_status_reg, 8'h10);
      cmd("*ESE 255");
      q("*ESE?", "255");
      cmd("*SRE 32");
      q("*sre?", "32");
      chk({event_enable_reg, service_enable_reg}, 16'hFF20);
      chk({status_byte[5], srq}, 2'h3);
      cmd("*CLS");
      chk({event_status_reg, srq}, 9'h000);
      ops_busy <= 1'b1;
      cmd("*OPC");
      repeat (10) @(posedge clock);
      chk(event_status_reg, 8'h00);
      ops_busy <= 1'b0;
      repeat (3) @(posedge clock);
      chk({event_status_reg, srq}, 9'h003);
      cmd("*CLS");
      ops_busy <= 1'b1;
      gcp_host_model_inst.send("*OPC?\n");
      repeat (10) @(posedge clock);
      chk(tx_valid, 1'b0);
      ops_busy <= 1'b0;
      gcp_host_model_inst.recv(resp);
      chk(resp, "1");
      ops_busy <= 1'b1;
      gcp_host_model_inst.send("*WAI\n");
      repeat (10) @(posedge clock);
      chk(rx_ready, 1'b0);
      ops_busy <= 1'b0;
      cmd("*TRG");
      get_in <= 1'b1;
      @(posedge clock);
      get_in <= 1'b0;
      repeat (2) @(posedge clock);
      chk(trig_n, 2);
      cmd("*RST");
      chk(pre_n, 1);
      tst_fail <= 15'h4001;
      q("*TST?", "16385");
      gcp_host_model_inst.slow = 1'b1;
      q("*IDN?", "FC01,GEN0,0,1");
      state_snapshot <= 32'hA5A50003;
      cmd("*SAV 3");
      state_snapshot <= 32'h5A5A0009;
      cmd("*SAV 9");
      cmd("*RCL 3");
      repeat (3) @(posedge clock);
      chk(ld, 32'hA5A50003);
      cmd("*CLS");
      cmd("*SAV 10");
      chk(event_status_reg, 8'h10);
      foreach (sm[i]) begin
         cmd(sm[i]);
         chk(val, sv[i]);
         chk(unit, i < 7 ? 2'h1 : i == 7 ? 2'h0 : 2'h2);
      end
      chk(dev_header, "T");
      end_summary <= 1'b1;
      err_summary <= 1'b1;
      @(posedge clock);
      chk(status_byte[1:0], 2'h3);
      q("*STB?", "99");
      cmd("*CLS");
      gcp_host_model_inst.send("*ES");
      get_in <= 1'b1;
      @(posedge clock);
      get_in <= 1'b0;
      repeat (2) @(posedge clock);
      chk(event_status_reg, 8'h20);
      chk(cls_n, 4);
      end_sim();
   end
endmodule // gcp_parser_tb_top

// File: gcp_state_mem.v
// Ten-slot memory of saved device states with registered read data
`timescale 1ns/10ps
`include "gcp_defines.vh"
module gcp_state_mem (
   input wire clock,
   input wire wr_en,
   input wire [3:0] wr_addr,
   input wire [`GCP_STATE_W-1:0] wr_data,
   input wire rd_en,
   input wire [3:0] rd_addr,
   output reg [`GCP_STATE_W-1:0] rd_data
);
   reg [`GCP_STATE_W-1:0] mem [0:`GCP_SLOTS-1];

   // Write and registered read
   always @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // gcp_state_mem
